// ===== design/host_control_interface.v
// host control port: parallel and serial access to the register space
// assumes pins come from outside the clock domain; events are on clk
`timescale 1ns/1ps
`default_nettype none
`include "hci_regs.vh"

module host_control_interface (
  // clock and reset
  input wire clk,
  input wire reset,
  // mode straps
  input wire [2:0] interface_select,
  input wire byte_swap_select,
  input wire clear_on_read_select,
  input wire broadcast_write_mode,
  // parallel bus
  input wire rd_n,
  input wire wr_n,
  input wire data_strobe_n,
  input wire read_write,
  input wire ale,
  input wire [9:0] addr,
  input wire [15:0] data_in,
  output wire [15:0] data_out,
  output wire [15:0] data_oe,
  // serial bus
  input wire cs_n,
  input wire sclk,
  input wire sdi,
  input wire cpol,
  input wire cpha,
  output wire sdo,
  output wire sdo_oe,
  // status events
  input wire [15:0] events,
  output wire [15:0] latched_status
);

  function [15:0] swap16;
    input [15:0] v;
    begin
      swap16 = {v[7:0], v[15:8]};
    end
  endfunction

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  reg [`HCI_SYNC_W-1:0] sync1_r;
  reg [`HCI_SYNC_W-1:0] sync2_r;
  wire [`HCI_SYNC_W-1:0] pins;

  // strobes enter inverted so a cleared stage reads as idle
  assign pins = {interface_select, byte_swap_select, clear_on_read_select,
                 broadcast_write_mode, ~rd_n, ~wr_n, ~data_strobe_n, read_write,
                 ale, addr, data_in, ~cs_n, sclk, sdi, cpol, cpha};

  always @(posedge clk)
  begin
    if (reset)
    begin
      sync1_r <= {`HCI_SYNC_W{1'b0}};
      sync2_r <= {`HCI_SYNC_W{1'b0}};
    end
    else
    begin
      sync1_r <= pins;
      sync2_r <= sync1_r;
    end
  end

  wire [2:0] isel_s = sync2_r[41:39];
  wire byte_swap_select_s = sync2_r[38];
  wire cor_s = sync2_r[37];
  wire bwm_s = sync2_r[36];
  wire rd_s = sync2_r[35];
  wire wr_s = sync2_r[34];
  wire ds_s = sync2_r[33];
  wire rw_s = sync2_r[32];
  wire ale_s = sync2_r[31];
  wire [9:0] addr_s = sync2_r[30:21];
  wire [15:0] din_s = sync2_r[20:5];
  wire cs_s = sync2_r[4];
  wire sclk_s = sync2_r[3];
  wire sdi_s = sync2_r[2];
  wire cpol_s = sync2_r[1];
  wire cpha_s = sync2_r[0];

  wire par_mode = isel_s[2];
  wire wide = isel_s[1];
  wire spi_mode = (isel_s[2:1] == 2'b01);

  // ---------------------------------------------------------------
  // parallel cycle detection
  // ---------------------------------------------------------------
  reg [9:0] alat_r;
  reg prd_q_r;
  reg wr_q_r;
  reg ds_q_r;
  reg rw_q_r;
  wire prd_now;
  wire prd_end;
  wire pwr_end;

  assign prd_now = par_mode && (isel_s[0] ? (ds_s && rw_s) : rd_s);
  assign prd_end = prd_q_r && !prd_now;
  assign pwr_end = par_mode && (isel_s[0] ? (ds_q_r && !ds_s && !rw_q_r)
                                          : (wr_q_r && !wr_s));

  always @(posedge clk)
  begin
    if (reset)
    begin
      alat_r <= 10'h000;
      prd_q_r <= 1'b0;
      wr_q_r <= 1'b0;
      ds_q_r <= 1'b0;
      rw_q_r <= 1'b0;
    end
    else
    begin
      // muxed address arrives on address pins
      if (ale_s)
        alat_r <= addr_s;
      prd_q_r <= prd_now;
      wr_q_r <= wr_s;
      ds_q_r <= ds_s;
      rw_q_r <= rw_s;
    end
  end

  // ---------------------------------------------------------------
  // serial slave
  // ---------------------------------------------------------------
  wire spi_rd_req;
  wire spi_wr_req;
  wire [9:0] spi_addr;
  wire [7:0] spi_wdata;
  reg spi_rv_r;
  wire [7:0] rd_byte;

  hci_spi_slave u_spi (
    .clk(clk),
    .reset(reset),
    .en(spi_mode),
    .lsb_first(isel_s[0]),
    .cpol(cpol_s),
    .cpha(cpha_s),
    .cs_n(~cs_s),
    .sclk(sclk_s),
    .sdi(sdi_s),
    .rd_req_r(spi_rd_req),
    .wr_req_r(spi_wr_req),
    .addr_r(spi_addr),
    .wdata_r(spi_wdata),
    .rd_data(rd_byte),
    .rd_valid(spi_rv_r),
    .sdo_r(sdo),
    .sdo_oe_r(sdo_oe)
  );

  // ---------------------------------------------------------------
  // request merge
  // ---------------------------------------------------------------
  wire rq_rd = prd_now || spi_rd_req;
  wire rq_wr = pwr_end || spi_wr_req;
  wire [9:0] rq_addr = spi_mode ? spi_addr : alat_r;
  wire rq_wide = par_mode && wide;
  wire [15:0] rq_wdata;
  wire [1:0] rq_be;
  wire rq_lsr = (rq_addr[9:1] == `HCI_LSR_WADDR);

  assign rq_wdata = rq_wide ? (byte_swap_select_s ? swap16(din_s) : din_s)
                  : (spi_mode ? {spi_wdata, spi_wdata} : {din_s[7:0], din_s[7:0]});
  assign rq_be = rq_wide ? 2'b11 : (rq_addr[0] ? 2'b10 : 2'b01);

  // ---------------------------------------------------------------
  // write sequencer, repeats over port copies in broadcast mode
  // ---------------------------------------------------------------
  reg wq_on_r;
  reg [1:0] wq_port_r;
  reg [1:0] wq_left_r;
  reg [8:0] wq_addr_r;
  reg [15:0] wq_data_r;
  reg [1:0] wq_be_r;
  wire [8:0] mem_addr;
  wire [15:0] mem_rdata;

  assign mem_addr = wq_on_r ? {wq_port_r, wq_addr_r[`HCI_PORT_LO-1:0]} : rq_addr[9:1];

  always @(posedge clk)
  begin
    if (reset)
    begin
      wq_on_r <= 1'b0;
      wq_port_r <= 2'h0;
      wq_left_r <= 2'h0;
      wq_addr_r <= 9'h000;
      wq_data_r <= 16'h0000;
      wq_be_r <= 2'b00;
    end
    else if (wq_on_r)
    begin
      if (wq_left_r == 2'h0)
        wq_on_r <= 1'b0;
      wq_left_r <= wq_left_r - 2'h1;
      wq_port_r <= wq_port_r + 2'h1;
    end
    else if (rq_wr && !rq_lsr)
    begin
      wq_on_r <= 1'b1;
      wq_addr_r <= rq_addr[9:1];
      wq_data_r <= rq_wdata;
      wq_be_r <= rq_be;
      wq_left_r <= bwm_s ? `HCI_PORT_LAST : 2'h0;
      wq_port_r <= bwm_s ? 2'h0 : rq_addr[`HCI_PORT_HI+1:`HCI_PORT_LO+1];
    end
  end

  hci_reg_mem u_mem (
    .clk(clk),
    .reset(reset),
    .we(wq_on_r),
    .be(wq_be_r),
    .addr(mem_addr),
    .wdata(wq_data_r),
    .rdata_r(mem_rdata)
  );

  // ---------------------------------------------------------------
  // latched status register
  // ---------------------------------------------------------------
  reg [15:0] lsr_r;
  reg [15:0] pend_r;
  reg [15:0] lsr_cap_r;
  reg rd_lsr_q_r;
  reg rd_a0_q_r;
  wire lsr_reading;
  reg [15:0] lsr_clr;

  assign lsr_reading = rq_rd && rq_lsr;
  assign latched_status = lsr_r;

  always @*
  begin
    lsr_clr = 16'h0000;
    if (rq_wr && rq_lsr && !cor_s)
      lsr_clr = rq_wdata & {{8{rq_be[1]}}, {8{rq_be[0]}}};
    if (cor_s && ((prd_end && (alat_r[9:1] == `HCI_LSR_WADDR)) ||
                  (spi_rd_req && rq_lsr)))
      lsr_clr = 16'hFFFF;
  end

  always @(posedge clk)
  begin
    if (reset)
    begin
      lsr_r <= `HCI_LSR_RST;
      pend_r <= 16'h0000;
      lsr_cap_r <= 16'h0000;
      rd_lsr_q_r <= 1'b0;
      rd_a0_q_r <= 1'b0;
      spi_rv_r <= 1'b0;
    end
    else
    begin
      // hold events during read, set wins
      if (lsr_reading)
      begin
        pend_r <= pend_r | events;
        lsr_r <= lsr_r & ~lsr_clr;
      end
      else
      begin
        pend_r <= 16'h0000;
        lsr_r <= (lsr_r & ~lsr_clr) | events | pend_r;
      end
      lsr_cap_r <= lsr_r;
      rd_lsr_q_r <= rq_lsr;
      rd_a0_q_r <= rq_addr[0];
      spi_rv_r <= spi_rd_req;
    end
  end

  // ---------------------------------------------------------------
  // read data return
  // ---------------------------------------------------------------
  reg [15:0] dout_r;
  reg [15:0] doe_r;
  wire [15:0] rd_word = rd_lsr_q_r ? lsr_cap_r : mem_rdata;

  assign rd_byte = rd_a0_q_r ? rd_word[15:8] : rd_word[7:0];
  assign data_out = dout_r;
  assign data_oe = doe_r;

  always @(posedge clk)
  begin
    if (reset)
    begin
      dout_r <= 16'h0000;
      doe_r <= 16'h0000;
    end
    else if (prd_now && prd_q_r)
    begin
      // upper lanes off in 8-bit mode
      dout_r <= wide ? (byte_swap_select_s ? swap16(rd_word) : rd_word) : {8'h00, rd_byte};
      doe_r <= wide ? 16'hFFFF : 16'h00FF;
    end
    else
    begin
      doe_r <= 16'h0000;
    end
  end

endmodule
`default_nettype wire

// ===== design/hci_regs.vh
// constants shared by the host control interface design files
// assumes inclusion by bare name from every design file
//
// Operation
// - no swap: register bytes keep their lanes
// - swap select high exchanges register bytes in 16-bit mode
// - select 1X0: read and write strobes
// - select 1X1: data strobe with direction
// - address latched under ALE or transparent
// - clear mode 0: write one clears bit
// - clear mode 1: read clears whole register
// - events during read set afterwards
// - broadcast write reaches every port copy
// - select 01X: serial slave port
// - serial output released unless shifting data
// - select 010 MSB first, 011 LSB
// - polarity pin sets serial clock idle
// - phase picks sample and update edges
// - sixteen bit control word leads transfer
// - decode direction, burst, drop upper address
// - LSB first reverses address bit order
// - burst write increments and wraps address
// - burst read prefetches and wraps address
// - chip select high resets serial logic
// - partial write byte is discarded
// - 8-bit uses A0; 16-bit excludes it
`ifndef HCI_REGS_VH
`define HCI_REGS_VH

// address space
`define HCI_MEM_AW 9
`define HCI_MEM_WORDS 512
`define HCI_PORT_LO 7
`define HCI_PORT_HI 8
`define HCI_PORT_LAST 2'h3
// word address of the latched status register
`define HCI_LSR_WADDR 9'h1F0
`define HCI_LSR_RST 16'h0000

// serial control word layout
`define HCI_CTL_BITS 5'h10
`define HCI_CTL_ADDR_LAST 5'h0E
`define HCI_CTL_BURST_POS 5'h0F
`define HCI_BYTE_LAST 3'h7

// synchroniser width
`define HCI_SYNC_W 42

`endif

// ===== design/hci_reg_mem.v
// register storage: 512 words of 16 bits, byte-lane writes
// assumes a single clock; read data appear one cycle after the address
`timescale 1ns/1ps
`default_nettype none
`include "hci_regs.vh"

module hci_reg_mem (
  // clock and reset
  input wire clk,
  input wire reset,
  // access port
  input wire we,
  input wire [1:0] be,
  input wire [8:0] addr,
  input wire [15:0] wdata,
  output reg [15:0] rdata_r
);

  reg [15:0] mem [0:`HCI_MEM_WORDS-1];

  always @(posedge clk)
  begin
    if (we && be[0])
      mem[addr][7:0] <= wdata[7:0];
    if (we && be[1])
      mem[addr][15:8] <= wdata[15:8];
  end

  always @(posedge clk)
  begin
    if (reset)
      rdata_r <= 16'h0000;
    else
      rdata_r <= mem[addr];
  end

endmodule
`default_nettype wire

// ===== design/hci_spi_slave.v
// serial slave: control word decode, single and burst byte transfers
// assumes all pin inputs already pass two flip-flops in the caller
`timescale 1ns/1ps
`default_nettype none
`include "hci_regs.vh"

module hci_spi_slave (
  // clock and reset
  input wire clk,
  input wire reset,
  // mode
  input wire en,
  input wire lsb_first,
  input wire cpol,
  input wire cpha,
  // synchronised pins
  input wire cs_n,
  input wire sclk,
  input wire sdi,
  // register access
  output reg rd_req_r,
  output reg wr_req_r,
  output reg [9:0] addr_r,
  output reg [7:0] wdata_r,
  input wire [7:0] rd_data,
  input wire rd_valid,
  // serial output
  output reg sdo_r,
  output reg sdo_oe_r
);

  function [13:0] rev14;
    input [13:0] v;
    integer i;
    begin
      for (i = 0; i < 14; i = i + 1)
        rev14[i] = v[13-i];
    end
  endfunction

  reg sclk_q_r;
  reg [4:0] cnt_r;
  reg [15:0] sh_r;
  reg rw_r;
  reg burst_r;
  reg done_r;
  reg inc_r;
  reg [2:0] dcnt_r;
  reg [7:0] rx_r;
  reg [2:0] txi_r;
  reg [7:0] tx_r;
  reg [7:0] pf_r;
  wire active;
  wire lead;
  wire trail;
  wire samp;
  wire shft;
  wire [13:0] ctl_addr;
  wire [7:0] rx_nxt;

  assign active = en && !cs_n;
  assign lead = (sclk != sclk_q_r) && (sclk == ~cpol);
  assign trail = (sclk != sclk_q_r) && (sclk == cpol);
  assign samp = cpha ? trail : lead;
  assign shft = cpha ? lead : trail;
  assign ctl_addr = lsb_first ? rev14({sh_r[12:0], sdi}) : {sh_r[12:0], sdi};
  assign rx_nxt = lsb_first ? {sdi, rx_r[7:1]} : {rx_r[6:0], sdi};

  always @(posedge clk)
  begin
    if (reset)
      sclk_q_r <= 1'b0;
    else
      sclk_q_r <= sclk;
  end

  always @(posedge clk)
  begin
    if (reset || !active)
    begin
      cnt_r <= 5'h00;
      sh_r <= 16'h0000;
      rw_r <= 1'b0;
      burst_r <= 1'b0;
      done_r <= 1'b0;
      inc_r <= 1'b0;
      dcnt_r <= 3'h0;
      rx_r <= 8'h00;
      txi_r <= 3'h0;
      tx_r <= 8'h00;
      pf_r <= 8'h00;
      rd_req_r <= 1'b0;
      wr_req_r <= 1'b0;
      addr_r <= 10'h000;
      wdata_r <= 8'h00;
      sdo_r <= 1'b0;
      sdo_oe_r <= 1'b0;
    end
    else
    begin
      rd_req_r <= 1'b0;
      wr_req_r <= 1'b0;
      if (rd_valid)
        pf_r <= rd_data;
      if (samp)
      begin
        if (cnt_r < `HCI_CTL_BITS)
        begin
          sh_r <= {sh_r[14:0], sdi};
          cnt_r <= cnt_r + 5'h01;
          if (cnt_r == `HCI_CTL_ADDR_LAST)
          begin
            rw_r <= sh_r[13];
            addr_r <= ctl_addr[9:0];
            rd_req_r <= sh_r[13];
          end
          if (cnt_r == `HCI_CTL_BURST_POS)
            burst_r <= sdi;
        end
        else if (!done_r)
        begin
          rx_r <= rx_nxt;
          dcnt_r <= dcnt_r + 3'h1;
          if (dcnt_r == `HCI_BYTE_LAST)
          begin
            if (!rw_r)
            begin
              wr_req_r <= 1'b1;
              wdata_r <= rx_nxt;
              inc_r <= burst_r;
            end
            if (!burst_r)
            begin
              done_r <= 1'b1;
              sdo_oe_r <= 1'b0;
            end
          end
        end
      end
      if (shft && rw_r && (cnt_r == `HCI_CTL_BITS) && !done_r)
      begin
        txi_r <= txi_r + 3'h1;
        sdo_oe_r <= 1'b1;
        if (txi_r == 3'h0)
        begin
          sdo_r <= lsb_first ? pf_r[0] : pf_r[7];
          tx_r <= lsb_first ? {1'b0, pf_r[7:1]} : {pf_r[6:0], 1'b0};
          inc_r <= burst_r;
        end
        else
        begin
          sdo_r <= lsb_first ? tx_r[0] : tx_r[7];
          tx_r <= lsb_first ? {1'b0, tx_r[7:1]} : {tx_r[6:0], 1'b0};
        end
      end
      if (inc_r)
      begin
        // wraps from 3FF to 000 by width
        addr_r <= addr_r + 10'h001;
        inc_r <= 1'b0;
        rd_req_r <= rw_r;
      end
    end
  end

endmodule
`default_nettype wire

// ===== verif/hci_chk.sv
// pin assertions for the host control port
// assumes binding to host_control_interface with one clock
`timescale 1ns/1ps
`default_nettype none
module hci_chk (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // straps and strobes
  input wire logic [2:0] interface_select,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic data_strobe_n,
  input wire logic read_write,
  input wire logic cs_n,
  input wire logic [15:0] events,
  // outputs
  input wire logic [15:0] data_oe,
  input wire logic sdo_oe,
  input wire logic [15:0] latched_status
);
  logic [3:0] idle_r;
  logic [3:0] idle_nxt;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // ----
  // cycles with no access, saturating
  // ----
  always_comb
  begin
    idle_nxt = idle_r;
    if (!(rd_n && wr_n && data_strobe_n && cs_n))
      idle_nxt = 4'h0;
    else if (idle_r != 4'hF)
      idle_nxt = idle_r + 4'h1;
  end
  always_ff @(posedge clk)
  begin
    if (reset)
      idle_r <= 4'h0;
    else
      idle_r <= idle_nxt;
  end
  sdo_released_a: assert property (cs_n [*4] |-> !sdo_oe)
    else $error("sdo driven while deselected");
  par_off_a: assert property (!interface_select[2] [*4] |-> data_oe == 16'h0000)
    else $error("parallel bus driven in serial mode");
  narrow_lane_a: assert property ((data_oe != 16'h0000) &&
    (interface_select[2:1] == 2'b10) |-> data_oe == 16'h00FF)
    else $error("8-bit lanes wrong");
  wide_lane_a: assert property ((data_oe != 16'h0000) &&
    (interface_select[2:1] == 2'b11) |-> data_oe == 16'hFFFF)
    else $error("16-bit lanes wrong");
  rd_cause_a: assert property ($rose(data_oe[0]) |->
    (!interface_select[0] && !$past(rd_n, 2)) ||
    (interface_select[0] && !$past(data_strobe_n, 2) && $past(read_write, 2)))
    else $error("bus driven without a read");
  rd_end_a: assert property ((rd_n && data_strobe_n) [*4] |-> data_oe == 16'h0000)
    else $error("bus still driven after read");
  ev_kept_a: assert property (events[0] |-> ##[1:20] latched_status[0])
    else $error("event lost");
  no_spont_a: assert property (idle_r == 4'hF |-> !$fell(latched_status[0]))
    else $error("status cleared without access");
  sdo_sel_a: assert property ($rose(sdo_oe) |-> !cs_n && !$past(cs_n, 3))
    else $error("sdo driven outside a frame");
  cover property ($rose(sdo_oe));
  cover property ($rose(data_oe[15]));
  cover property ($fell(latched_status[0]));
endmodule
bind host_control_interface hci_chk u_chk (.clk(clk), .reset(reset),
  .interface_select(interface_select), .rd_n(rd_n), .wr_n(wr_n),
  .data_strobe_n(data_strobe_n), .read_write(read_write), .cs_n(cs_n),
  .events(events), .data_oe(data_oe), .sdo_oe(sdo_oe), .latched_status(latched_status));
`default_nettype wire

// ===== verif/hci_spi_host.sv
// serial bus master standing in for the host processor
// assumes mode inputs are settled before each frame starts
`timescale 1ns/1ps
`default_nettype none
module hci_spi_host (
  // mode
  input wire logic cpol,
  input wire logic cpha,
  input wire logic lsb,
  // serial pins
  output var logic cs_n,
  output var logic sclk,
  output var logic sdi,
  input wire logic sdo
);
  initial
  begin
    cs_n = 1'b1;
    sclk = 1'b0;
    sdi = 1'b0;
  end
  task bit_x(input logic b, output logic r);
    if (!cpha)
      sdi = b;
    #24 sclk = ~cpol;
    if (cpha)
      sdi = b;
    else
      r = sdo;
    #24 sclk = cpol;
    if (cpha)
      r = sdo;
  endtask
  task xfer(input logic [15:0] ctl, input integer nbits, input logic [15:0] wd,
    output logic [15:0] rd);
    integer i;
    integer idx;
    logic r;
    rd = 16'h0000;
    #1.3 sclk = cpol;
    #30 cs_n = 1'b0;
    for (i = 0; i < nbits; i = i + 1)
    begin
      if (i < 16)
        bit_x((lsb && i > 0 && i < 15) ? ctl[i] : ctl[15 - i], r);
      else
      begin
        idx = ((i - 16) & ~7) + (lsb ? (i % 8) : 7 - (i % 8));
        // released line toggles during reads
        bit_x(ctl[15] ? ~sdi : wd[idx], r);
        rd[idx] = r;
      end
    end
    #30 cs_n = 1'b1;
    #60;
  endtask
endmodule
`default_nettype wire

// ===== verif/testbench.sv
// self-checking bench for the host control port
// assumes the serial master model and the checker compile first
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk, reset, bsw, cor, bwm, rd_n, wr_n, ds_n, rw, ale, cpol, cpha;
  logic [2:0] isel;
  logic [9:0] addr;
  logic [15:0] din, events, q, rd;
  logic [7:0] b0, b1;
  wire logic [15:0] dout, doe, lstat;
  wire logic sdo, sdo_oe, cs_n, sclk, sdi, sdo_pin;
  integer mismatches, n_tests, cyc, m;
  assign sdo_pin = sdo_oe ? sdo : 1'bz;
  host_control_interface DUT (.clk(clk), .reset(reset), .interface_select(isel),
    .byte_swap_select(bsw), .clear_on_read_select(cor), .broadcast_write_mode(bwm),
    .rd_n(rd_n), .wr_n(wr_n), .data_strobe_n(ds_n), .read_write(rw), .ale(ale),
    .addr(addr), .data_in(din), .data_out(dout), .data_oe(doe), .cs_n(cs_n),
    .sclk(sclk), .sdi(sdi), .cpol(cpol), .cpha(cpha), .sdo(sdo), .sdo_oe(sdo_oe),
    .events(events), .latched_status(lstat));
  hci_spi_host host (.cpol(cpol), .cpha(cpha), .lsb(isel[0]), .cs_n(cs_n),
    .sclk(sclk), .sdi(sdi), .sdo(sdo_pin));
  initial
  begin
    clk = 1'b0;
    forever
      #2.5 clk = ~clk;
  end
  task chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests = n_tests + 1;
    if (got !== exp)
    begin
      mismatches = mismatches + 1;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task strobe(input logic r);
    repeat (2) @(posedge clk);
    if (isel[0])
      ds_n <= 1'b0;
    else if (r)
      rd_n <= 1'b0;
    else
      wr_n <= 1'b0;
    repeat (5) @(posedge clk);
    // look at read data between edges, never on the edge that updates it
    @(negedge clk);
    q = dout;
    @(posedge clk);
    ds_n <= 1'b1;
    rd_n <= 1'b1;
    wr_n <= 1'b1;
    repeat (7) @(posedge clk);
  endtask
  task par_wr(input logic [9:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    din <= d;
    rw <= 1'b0;
    strobe(1'b0);
  endtask
  task par_rd(input logic [9:0] a);
    @(posedge clk);
    addr <= a;
    rw <= 1'b1;
    strobe(1'b1);
  endtask
  task pulse;
    events <= 16'h0001;
    @(posedge clk);
    events <= 16'h0000;
    repeat (3) @(posedge clk);
  endtask
  task t_lanes;
    isel <= 3'b110;
    par_wr(10'h004, 16'h12C3);
    par_rd(10'h004);
    chk(q, 16'h12C3);
    bsw <= 1'b1;
    par_rd(10'h005);
    chk(q, 16'hC312);
    bsw <= 1'b0;
    isel <= 3'b100;
    par_rd(10'h005);
    chk(q & 16'h00FF, 16'h0012);
    isel <= 3'b101;
    par_wr(10'h009, 16'h0077);
    par_rd(10'h009);
    chk(q, 16'h0077);
    isel <= 3'b111;
    par_wr(10'h006, 16'hBEEF);
    par_rd(10'h006);
    chk(q, 16'hBEEF);
  endtask
  task t_ale;
    isel <= 3'b110;
    addr <= 10'h004;
    // address also driven on the data lines
    din <= 16'h0004;
    repeat (3) @(posedge clk);
    ale <= 1'b0;
    @(posedge clk);
    par_rd(10'h006);
    ale <= 1'b1;
    chk(q, 16'h12C3);
  endtask
  task t_status;
    pulse;
    chk(lstat, 16'h0001);
    par_wr(10'h3E0, 16'h0002);
    chk(lstat, 16'h0001);
    par_wr(10'h3E0, 16'h0001);
    chk(lstat, 16'h0000);
    cor <= 1'b1;
    pulse;
    par_rd(10'h3E0);
    chk(q, 16'h0001);
    chk(lstat, 16'h0000);
    fork
      par_rd(10'h3E0);
      begin
        repeat (6) @(posedge clk);
        pulse;
      end
    join
    chk(lstat, 16'h0001);
    cor <= 1'b0;
  endtask
  task t_bcast;
    bwm <= 1'b1;
    par_wr(10'h310, 16'h5AA5);
    bwm <= 1'b0;
    for (m = 0; m < 4; m = m + 1)
    begin
      par_rd({m[1:0], 8'h10});
      chk(q, 16'h5AA5);
    end
  endtask
  task t_spi;
    for (m = 0; m < 8; m = m + 1)
    begin
      @(posedge clk);
      isel <= {2'b01, m[2]};
      cpol <= m[1];
      cpha <= m[0];
      b0 = 8'h50 + m[7:0];
      b1 = 8'hA0 + m[7:0];
      repeat (4) @(posedge clk);
      host.xfer({1'b0, 14'h3FFF, 1'b1}, 32, {b1, b0}, rd);
      host.xfer({1'b1, 14'h3FFF, 1'b1}, 32, 16'h0000, rd);
      chk(rd, {b1, b0});
      host.xfer({1'b1, 14'h03FF, 1'b0}, 32, 16'h0000, rd);
      chk(rd, {8'hZZ, b0});
    end
    host.xfer({1'b0, 14'h03FF, 1'b0}, 21, 16'h00FF, rd);
    host.xfer({1'b1, 14'h03FF, 1'b0}, 24, 16'h0000, rd);
    chk(rd, {8'h00, b0});
    @(posedge clk);
    isel <= 3'b110;
    par_rd(10'h3FE);
    chk(q & 16'hFF00, {b0, 8'h00});
    par_rd(10'h000);
    chk(q & 16'h00FF, {8'h00, b1});
  endtask
  task final_report;
    $display("mismatches %0d n_tests %0d", mismatches, n_tests);
    if (mismatches == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial
  begin
    {bsw, cor, bwm, cpol, cpha} = 5'h00;
    {rd_n, wr_n, ds_n, rw, ale} = 5'h1F;
    isel = 3'b110;
    addr = 10'h000;
    din = 16'h0000;
    events = 16'h0000;
    mismatches = 0;
    n_tests = 0;
    cyc = 0;
    reset = 1'b1;
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    t_lanes;
    t_ale;
    t_status;
    t_bcast;
    t_spi;
    final_report;
  end
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      mismatches = mismatches + 1;
      final_report;
    end
  end
endmodule
`default_nettype wire
